// ---- core/pcr_host.sv ----
/*
  host processor end: turns single user commands into I/O cycles on the
  link and returns the read data.
  assumes one outstanding command; software does read-merge-write itself.
*/
`default_nettype none
module pcr_host
  import pcr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  pcr_if.host              link,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [15:0] cmd_addr,
  input  wire logic [3:0]  cmd_be,
  input  wire logic [31:0] cmd_wdata,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata
);
  import pcr_pkg::*;

  logic busy_q;

  // address port is loaded only with dword writes by well-behaved software
  // reserved bits merged by software, not here bus scan order is software's
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_q         <= 1'b0;
      link.io_req    <= 1'b0;
      link.io_write  <= 1'b0;
      link.io_addr   <= 16'h0000;
      link.io_be     <= 4'h0;
      link.io_wdata  <= 32'h0000_0000;
    end else if (!busy_q && cmd_valid) begin
      busy_q         <= 1'b1;
      link.io_req    <= 1'b1;
      link.io_write  <= cmd_write;
      link.io_addr   <= cmd_addr;
      link.io_be     <= cmd_be;
      link.io_wdata  <= cmd_wdata;
    end else if (busy_q && link.io_done) begin
      busy_q         <= 1'b0;
      link.io_req    <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 32'h0000_0000;
    end else begin
      cmd_ready <= !busy_q && !cmd_valid;
      rsp_valid <= busy_q && link.io_done;
      if (busy_q && link.io_done) begin
        rsp_rdata <= link.io_rdata;
      end
    end
  end
endmodule // pcr_host
`default_nettype wire

// ---- core/pcr_if.sv ----
/*
  interface joining the host processor end and the routing end.
  assumes both ends share one clock; the host holds a request until done.
*/
`default_nettype none
interface pcr_if (input wire logic clock);
  logic        io_req;
  logic        io_write;
  logic [15:0] io_addr;
  logic [3:0]  io_be;
  logic [31:0] io_wdata;
  logic        io_done;
  logic [31:0] io_rdata;
  modport host (input clock, output io_req, output io_write, output io_addr,
                output io_be, output io_wdata, input io_done, input io_rdata);
  modport router (input clock, input io_req, input io_write, input io_addr,
                  input io_be, input io_wdata, output io_done, output io_rdata);
endinterface
`default_nettype wire

// ---- core/pcr_pkg.sv ----
/*
  package for the configuration access router: port offsets, address field
  positions, routing targets and reset values.
  assumes a single 250 MHz host clock and synchronous active-high reset.
*/
`default_nettype none
package pcr_pkg;
  localparam logic [15:0] ADDR_PORT_OFS   = 16'h0cf8;
  localparam logic [15:0] DATA_WIN_OFS    = 16'h0cfc;
  localparam int          ENABLE_BIT      = 31;
  localparam int          BUS_LSB         = 16;
  localparam int          DEV_LSB         = 11;
  localparam int          FUNC_LSB        = 8;
  localparam int          REG_LSB         = 2;
  localparam logic [31:0] ADDR_FIELD_MASK = 32'h80ff_fffc;
  localparam logic [31:0] ADDR_RESET      = 32'h0000_0000;
  localparam logic [4:0]  HUB_BRIDGE_DEV  = 5'h00;
  localparam logic [4:0]  GFX_BRIDGE_DEV  = 5'h01;
  localparam logic [7:0]  PRIMARY_BUS_NUM = 8'h00;
  localparam logic [1:0]  TYPE1_LOW_BITS  = 2'h1;
  localparam logic [1:0]  TYPE0_LOW_BITS  = 2'h0;
  localparam logic [3:0]  BE_DWORD        = 4'hf;
  localparam int          NUM_INT_DEV     = 2;

  typedef enum logic [2:0] {
    PCR_TGT_INTERNAL = 3'b000,
    PCR_TGT_HUB_T0   = 3'b001,
    PCR_TGT_HUB_T1   = 3'b010,
    PCR_TGT_GFX_T0   = 3'b011,
    PCR_TGT_GFX_T1   = 3'b100,
    PCR_TGT_HUB_IO   = 3'b101,
    PCR_TGT_NONE     = 3'b110
  } pcr_target_e;
endpackage
`default_nettype wire

// ---- core/pcr_router.sv ----
/*
  configuration access router: address port and data window in host I/O
  space, routing of each configuration cycle to the internal devices, the
  hub link or the secondary graphics bus.
  assumes one host request at a time, held until io_done; far side
  completions are given by cfg_done.
*/
// Notes on behaviour
// - only mechanism one, no mechanism two
// - address port 0cf8-0cfb, data window 0cfc-0cff
// - address port loaded only by dword writes
// - cycles generated only while enable bit set
// - data window access becomes configuration cycle
// - bus number zero targets bus zero
// - hub bridge device 0, graphics bridge 1
// - enabled internal hits never reach hub link
// - disabled internal devices forwarded as type 0
// - out-of-range bus gives hub type 1, low 01
// - graphics bridge primary bus fixed zero
// - secondary bus gives graphics type 0, idsel
// - bus within subordinate range gives graphics type 1
// - internal registers take byte, word, dword lanes
// - full reset loads defaults, straps taken one cycle after release
// - software merges reserved bits except address port
// - software scans bus zero then assigns buses
// - device, function, register fields drive address
// - partial address port access passes through
// - internal devices ignore nonzero function numbers
`default_nettype none
module pcr_router
  import pcr_pkg::*;
#(
  parameter int IDSEL_BASE = 16
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  pcr_if.router            link,
  input  wire logic [1:0]  int_dev_strap,
  input  wire logic [7:0]  secondary_bus_num,
  input  wire logic [7:0]  subordinate_bus_num,
  output logic             cfg_valid,
  output pcr_pkg::pcr_target_e cfg_target,
  output logic             cfg_write,
  output logic [31:0]      cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  output logic [31:0]      graphics_addr_data_lines,
  output logic [7:0]       gfx_primary_bus,
  output logic [1:0]       int_dev_enabled,
  input  wire logic        cfg_done,
  input  wire logic [31:0] cfg_rdata
);
  import pcr_pkg::*;

  // idsel lines sit above the function and register fields of a type 0 address;
  // a base above 31 would leave every device without a line
  if (IDSEL_BASE < 11 || IDSEL_BASE > 31) begin : g_bad_idsel_base
    $error("idsel base must lie between address bits 11 and 31");
  end

  logic [31:0] addr_port_q;
  logic        strap_taken_q;
  logic        pending_q;
  logic        cfg_space_enable;
  logic [7:0]  bus_num;
  logic [4:0]  dev_num;
  logic [2:0]  func_num;
  logic        hit_addr;
  logic        hit_data;
  logic        dword;
  pcr_target_e tgt_d;
  logic [31:0] addr_d;
  logic [31:0] idsel_d;

  assign cfg_space_enable = addr_port_q[ENABLE_BIT];
  assign bus_num  = addr_port_q[BUS_LSB +: 8];
  assign dev_num  = addr_port_q[DEV_LSB +: 5];
  assign func_num = addr_port_q[FUNC_LSB +: 3];
  // mechanism one only: the byte registers of the second scheme at 0cf8 and 0cfa
  // fall on the address port and so pass through as plain I/O
  assign hit_addr = (link.io_addr[15:2] == ADDR_PORT_OFS[15:2]);
  assign hit_data = (link.io_addr[15:2] == DATA_WIN_OFS[15:2]);
  // a dword access needs all four lanes at the aligned address
  assign dword    = (link.io_be == BE_DWORD) && (link.io_addr[1:0] == 2'h0);

  // one-hot idsel for the secondary bus: device n drives line IDSEL_BASE + n;
  // devices with no line left get a type 0 cycle that nobody claims
  for (genvar g = 0; g < 32; g++) begin : g_idsel
    if (g >= IDSEL_BASE) begin : g_line
      assign idsel_d[g] = (32'(dev_num) == 32'(g - IDSEL_BASE));
    end else begin : g_none
      assign idsel_d[g] = 1'b0;
    end
  end

  // routing decision from the address port contents
  always_comb begin
    tgt_d   = PCR_TGT_NONE;
    addr_d  = {addr_port_q[31:2], TYPE0_LOW_BITS};
    if (hit_addr && !dword) begin
      tgt_d  = PCR_TGT_HUB_IO;
      addr_d = {16'h0000, link.io_addr};
    end else if (hit_data && !cfg_space_enable) begin
      tgt_d  = PCR_TGT_HUB_IO;
      addr_d = {16'h0000, link.io_addr};
    end else if (hit_data) begin
      if (bus_num == PRIMARY_BUS_NUM) begin
        if (dev_num == HUB_BRIDGE_DEV || dev_num == GFX_BRIDGE_DEV) begin
          if (!int_dev_enabled[dev_num[0]]) begin
            tgt_d = PCR_TGT_HUB_T0;
          end else if (func_num == 3'h0) begin
            tgt_d = PCR_TGT_INTERNAL;
          end else begin
            tgt_d = PCR_TGT_NONE;
          end
        end else begin
          tgt_d = PCR_TGT_HUB_T0;
        end
      end else if (bus_num == secondary_bus_num) begin
        tgt_d = PCR_TGT_GFX_T0;
        addr_d = {21'h000000, addr_port_q[10:2], TYPE0_LOW_BITS} | idsel_d;
      end else if (bus_num > secondary_bus_num && bus_num <= subordinate_bus_num) begin
        tgt_d  = PCR_TGT_GFX_T1;
        addr_d = {8'h00, addr_port_q[23:2], TYPE1_LOW_BITS};
      end else begin
        tgt_d  = PCR_TGT_HUB_T1;
        addr_d = {8'h00, addr_port_q[23:2], TYPE1_LOW_BITS};
      end
    end
  end

  // address port: dword writes only, reserved bits kept at zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addr_port_q <= ADDR_RESET;
      // ignored until the straps are in, like every other request
    end else if (link.io_req && !pending_q && strap_taken_q && hit_addr && dword &&
                 link.io_write) begin
      addr_port_q <= link.io_wdata & ADDR_FIELD_MASK;
    end
  end

  // strap capture after reset release, never inside the reset branch
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      strap_taken_q   <= 1'b0;
      int_dev_enabled <= 2'h0;
    end else if (!strap_taken_q) begin
      strap_taken_q   <= 1'b1;
      int_dev_enabled <= int_dev_strap;
    end
  end

  // one request per io_req; done pulses one cycle then waits for io_req low
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pending_q     <= 1'b0;
      cfg_valid     <= 1'b0;
      cfg_target    <= PCR_TGT_NONE;
      cfg_write     <= 1'b0;
      cfg_addr      <= 32'h0000_0000;
      cfg_be        <= 4'h0;
      cfg_wdata     <= 32'h0000_0000;
      graphics_addr_data_lines <= 32'h0000_0000;
      link.io_done  <= 1'b0;
      link.io_rdata <= 32'h0000_0000;
    end else begin
      link.io_done <= 1'b0;
      // pending_q blocks a second take of the same request until the host
      // drops io_req, so a held request is never turned into two cycles
      if (link.io_req && !pending_q && !link.io_done && strap_taken_q) begin
        pending_q <= 1'b1;
        if (hit_addr && dword) begin
          link.io_done  <= 1'b1;
          link.io_rdata <= link.io_write ? 32'h0000_0000 : addr_port_q;
        end else if (tgt_d == PCR_TGT_NONE) begin
          link.io_done  <= 1'b1; // ignored cycle reads as all ones
          link.io_rdata <= 32'hffff_ffff;
        end else begin
          cfg_valid  <= 1'b1;
          cfg_target <= tgt_d;
          cfg_write  <= link.io_write;
          cfg_addr   <= addr_d;
          cfg_be     <= link.io_be; // byte lanes pass unchanged
          cfg_wdata  <= link.io_wdata;
          graphics_addr_data_lines <= (tgt_d == PCR_TGT_GFX_T0) ? idsel_d : 32'h0000_0000;
        end
      end else if (cfg_valid && cfg_done) begin
        cfg_valid     <= 1'b0;
        graphics_addr_data_lines <= 32'h0000_0000;
        link.io_done  <= 1'b1;
        link.io_rdata <= cfg_write ? 32'h0000_0000 : cfg_rdata;
      end else if (!link.io_req) begin
        pending_q <= 1'b0;
      end
    end
  end

  // virtual graphics bridge primary bus is hardwired
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      gfx_primary_bus <= PRIMARY_BUS_NUM;
    end else begin
      gfx_primary_bus <= PRIMARY_BUS_NUM;
    end
  end
endmodule // pcr_router
`default_nettype wire

// ---- tb/pcr_props.sv ----
/* assertions on the host link between the host end and the router.
   assumes it is instantiated beside the link interface in the bench. */
`default_nettype none
module pcr_props
  import pcr_pkg::*;
(
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        io_req,
  input wire logic        io_write,
  input wire logic [15:0] io_addr,
  input wire logic [3:0]  io_be,
  input wire logic [31:0] io_wdata,
  input wire logic        io_done,
  input wire logic [31:0] io_rdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [31:0] port_q;
  // shadow of the address port; partial writes must leave it alone
  always_ff @(posedge clock) begin
    if (sys_rst) port_q <= ADDR_RESET;
    else if (io_done && io_write && io_addr == ADDR_PORT_OFS && io_be == BE_DWORD)
      port_q <= io_wdata & ADDR_FIELD_MASK;
  end
  sequence s_take; $rose(io_req); endsequence
  sequence s_port; $rose(io_req) && io_addr == ADDR_PORT_OFS && io_be == BE_DWORD; endsequence
  property p_port_fast; s_port |=> io_done; endproperty
  a_port_fast: assert property (p_port_fast) else $error("port access slow");
  property p_port_read; s_port ##0 !io_write |=> io_rdata == port_q; endproperty
  a_port_read: assert property (p_port_read) else $error("port readback");
  property p_unmapped;
    $rose(io_req) && io_addr[15:3] != ADDR_PORT_OFS[15:3] |=> io_done && io_rdata == 32'hffffffff;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access");
  property p_pulse; io_done |=> !io_done; endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_done_req; io_done |-> io_req; endproperty
  a_done_req: assert property (p_done_req) else $error("done without request");
  property p_bounded; s_take |-> ##[1:8] io_done; endproperty
  a_bounded: assert property (p_bounded) else $error("no completion");
  property p_wr_zero; io_done && io_write |-> io_rdata == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write data back");
  property p_held; io_req && !io_done |=> io_req && $stable(io_addr); endproperty
  a_held: assert property (p_held) else $error("request dropped");
endmodule // pcr_props
`default_nettype wire

// ---- tb/testbench.sv ----
/* bench joining host end and router through the link interface.
   assumes a far side that completes each cycle one clock after it starts. */
`default_nettype none
module testbench
  import pcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, cmd_write = 1'b0;
  logic [15:0] cmd_addr = 16'h0;
  logic [3:0]  cmd_be = 4'h0, cfg_be, got_be;
  logic [31:0] cmd_wdata = 32'h0, rsp_rdata, cfg_addr, cfg_wdata, gfx_lines, got_addr;
  logic [31:0] got_lines, got_wd, rd;
  logic cmd_ready, rsp_valid, cfg_valid, cfg_write, cfg_done = 1'b0, seen = 1'b0, got_wr;
  logic [7:0]  prim;
  logic [1:0]  en;
  wire logic [31:0] cfg_rdata;
  pcr_target_e cfg_target, got_tgt, last_tgt;
  int errors = 0, n_tests = 0, n_cfg = 0;
  logic [31:0] pv [8] = '{32'h8000_0008, 32'h8000_0810, 32'h8000_0910, 32'h8000_1814,
                          32'h8002_210c, 32'h8004_210c, 32'h8009_210c, 32'h8001_0000};
  logic [31:0] ea [8] = '{32'h8000_0008, 32'h0, 32'h0, 32'h8000_1814,
                          32'h0010_010c, 32'h0004_210d, 32'h0009_210d, 32'h0001_0001};
  pcr_target_e et [8] = '{PCR_TGT_HUB_T0, PCR_TGT_INTERNAL, PCR_TGT_NONE, PCR_TGT_HUB_T0,
                          PCR_TGT_GFX_T0, PCR_TGT_GFX_T1, PCR_TGT_HUB_T1, PCR_TGT_HUB_T1};
  always #2 clock = ~clock;
  assign cfg_rdata = ~cfg_addr;
  pcr_if u_pcr_if (.clock);
  pcr_host u_pcr_host (.clock, .sys_rst, .link(u_pcr_if), .cmd_valid, .cmd_write, .cmd_addr,
    .cmd_be, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata);
  pcr_router u_pcr_router (.clock, .sys_rst, .link(u_pcr_if), .int_dev_strap(2'b10),
    .secondary_bus_num(8'h02), .subordinate_bus_num(8'h05), .cfg_valid, .cfg_target,
    .cfg_write, .cfg_addr, .cfg_be, .cfg_wdata, .graphics_addr_data_lines(gfx_lines),
    .gfx_primary_bus(prim), .int_dev_enabled(en), .cfg_done, .cfg_rdata);
  pcr_props u_pcr_props (.clock, .sys_rst, .io_req(u_pcr_if.io_req),
    .io_write(u_pcr_if.io_write), .io_addr(u_pcr_if.io_addr), .io_be(u_pcr_if.io_be),
    .io_wdata(u_pcr_if.io_wdata), .io_done(u_pcr_if.io_done), .io_rdata(u_pcr_if.io_rdata));
  // far side answers one clock after a cycle starts and records what it saw
  always @(posedge clock) begin
    cfg_done <= cfg_valid && !seen;
    seen <= cfg_valid;
    if (cfg_valid && !seen) begin
      n_cfg <= n_cfg + 1;
      got_tgt <= cfg_target;
      got_addr <= cfg_addr;
      got_lines <= gfx_lines;
      got_be <= cfg_be;
      got_wr <= cfg_write;
      got_wd <= cfg_wdata;
    end
  end
  task automatic tally_and_finish();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_t(input string n, input pcr_target_e e, input pcr_target_e g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    int i;
    int c0;
    c0 = n_cfg;
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_be <= b;
    cmd_wdata <= d;
    @(posedge clock);
    cmd_valid <= 1'b0;
    for (i = 0; i < 20 && rsp_valid !== 1'b1; i++) @(posedge clock);
    if (rsp_valid !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    rd = rsp_rdata;
    // no far-side cycle during this access reads as no target
    last_tgt = (n_cfg != c0) ? got_tgt : PCR_TGT_NONE;
    @(posedge clock);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    acc(1'b0, ADDR_PORT_OFS, BE_DWORD, 32'h0);
    chk("port reset", ADDR_RESET, rd);
    chk("strap enables", 32'h2, {30'h0, en});
    chk("primary bus", 32'h0, {24'h0, prim});
    chk("ready idle", 32'h1, {31'h0, cmd_ready});
    acc(1'b1, ADDR_PORT_OFS, BE_DWORD, 32'hffff_ffff);
    acc(1'b0, ADDR_PORT_OFS, BE_DWORD, 32'h0);
    chk("port mask", 32'h80ff_fffc, rd);
    acc(1'b1, ADDR_PORT_OFS, 4'h1, 32'h0);
    chk_t("byte to port", PCR_TGT_HUB_IO, last_tgt);
    acc(1'b1, 16'h0cfa, 4'h4, 32'h0);
    chk_t("upper byte to port", PCR_TGT_HUB_IO, last_tgt);
    chk("pass addr", 32'h0000_0cfa, got_addr);
    acc(1'b0, ADDR_PORT_OFS, BE_DWORD, 32'h0);
    chk("port kept", 32'h80ff_fffc, rd);
    acc(1'b1, ADDR_PORT_OFS, BE_DWORD, 32'h0000_0810);
    acc(1'b0, DATA_WIN_OFS, BE_DWORD, 32'h0);
    chk_t("window off", PCR_TGT_HUB_IO, last_tgt);
    // bus zero entries come first, then buses 2 and 4 behind the bridge, then buses 9 and 1 outside its range
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, ADDR_PORT_OFS, BE_DWORD, pv[i]);
      acc(1'b0, DATA_WIN_OFS, BE_DWORD, 32'h0);
      chk_t("route", et[i], last_tgt);
      if (et[i] == PCR_TGT_NONE) chk("func ignored", 32'hffff_ffff, rd);
      else if (et[i] != PCR_TGT_INTERNAL) begin
        chk("cfg addr", ea[i], got_addr);
        chk("cfg rdata", ~ea[i], rd);
        chk("idsel", (et[i] == PCR_TGT_GFX_T0) ? 32'h0010_0000 : 32'h0, got_lines);
      end
    end
    acc(1'b1, DATA_WIN_OFS, 4'h3, 32'h1234_5678);
    chk("lanes", 32'h3, {28'h0, got_be});
    chk("cfg wdata", 32'h1234_5678, got_wd);
    chk("cfg write", 32'h1, {31'h0, got_wr});
    acc(1'b0, 16'h0080, BE_DWORD, 32'h0);
    chk("unmapped", 32'hffff_ffff, rd);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
